// ==== logic/blj_top.sv ====
/*
  Board LED control and jumper status register bank, a classic
  Wishbone slave, plus jumper driven board settings.
  Assumes jumper inputs are synchronous, high meaning fitted, and that
  the push-button reset is merged into arst_n by the board reset logic.
*/
// Design decision made here: the Wishbone register port.
// Contract
// - Both LEDs light from power-up until software writes them
// - LED location: bit 1 red, bit 0 green
// - Writing one lights an LED, zero turns it off
// - Four jumpers readable in one read-only status location
// - Active-high bits: console enable, flash write, second user jumper
// - Active-low bits: console swap bit 3, first user jumper bit 4
// - Boot recovery jumper selects boot over the first serial port
// - Console to first port, swap moves it to second, needs enable
// - Flash writable only while write-enable jumper fitted
// - Push-button reset returns all logic to power-on state
`timescale 1ns/1ps
module blj_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire blj_pkg::blj_jumpers_t jumpers,
  output logic led_red,
  output logic led_green,
  output blj_pkg::blj_settings_t settings
);
  import blj_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Status locations are one byte wide; upper lanes read zero
  function automatic logic [31:0] widen_byte(
    input logic [7:0] value
  );
    return {24'h00_0000, value};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0] led_q;
  logic ack_q;
  logic rd_req;
  logic led_wr;
  logic hit_main;
  logic hit_aux;
  logic hit_led;
  logic hit_set;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  blj_settings_t settings_q;
  blj_settings_t settings_d;
  logic [7:0] main_status;
  logic [7:0] aux_status;

  ////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  blj_wb_front u_bus (
    .clk(clk),
    .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .ack_q(ack_q),
    .rd_req(rd_req),
    .led_wr(led_wr),
    .hit_main(hit_main),
    .hit_aux(hit_aux),
    .hit_led(hit_led),
    .hit_set(hit_set)
  );

  blj_status_pack u_status (
    .jumpers(jumpers),
    .main_status(main_status),
    .aux_status(aux_status)
  );

  blj_settings_map u_settings (
    .jumpers(jumpers),
    .settings_d(settings_d)
  );

  blj_led_bank u_leds (
    .clk(clk),
    .arst_n(arst_n),
    .led_wr(led_wr),
    .wr_data(wb_dat_i),
    .led_q(led_q),
    .led_red(led_red),
    .led_green(led_green)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    rdata_d = RDATA_UNMAPPED;
    if (rd_req) begin
      if (hit_main) begin
        rdata_d = widen_byte(main_status);
      end else if (hit_aux) begin
        rdata_d = widen_byte(aux_status);
      end else if (hit_led) begin
        rdata_d = {30'h0000_0000, led_q};
      end else if (hit_set) begin
        rdata_d = {28'h000_0000, settings_q};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; arst_n carries power-on and push-button reset alike

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Settings lag the jumpers one cycle; harmless for static straps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settings_q <= '0;
    end else begin
      settings_q <= settings_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign settings = settings_q;

endmodule // blj_top

////////////////////////////////////////////////////////////////////////
// Wishbone front end: take, decode, acknowledge

module blj_wb_front (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  output logic ack_q,
  output logic rd_req,
  output logic led_wr,
  output logic hit_main,
  output logic hit_aux,
  output logic hit_led,
  output logic hit_set
);
  import blj_pkg::*;

  // Full compare on purpose: a partial decode would alias
  // the LED location into the jumper space
  function automatic logic addr_match(
    input logic [31:0] adr,
    input logic [31:0] base
  );
    return adr == base;
  endfunction

  logic req;
  logic wr_req;
  logic led_lane;
  logic ack_d;

  // Ack high blocks a second take of a strobe the master
  // has not yet released
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign rd_req = req && !wb_we_i;
  assign wr_req = req && wb_we_i;

  assign hit_main = addr_match(wb_adr_i, ADDR_JUMPER_STATUS_MAIN);
  assign hit_aux = addr_match(wb_adr_i, ADDR_JUMPER_STATUS_AUX);
  assign hit_led = addr_match(wb_adr_i, ADDR_LED_CONTROL);
  assign hit_set = addr_match(wb_adr_i, ADDR_BOARD_SETTINGS);

  // Only byte lane 0 holds LED bits; jumper locations take no write
  assign led_lane = wb_sel_i[0];
  assign led_wr = wr_req && hit_led && led_lane;

  // Unmapped addresses still ack, read zero, so software never hangs
  assign ack_d = req;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

endmodule // blj_wb_front

////////////////////////////////////////////////////////////////////////
// Jumper status bytes as software reads them

module blj_status_pack (
  input wire blj_pkg::blj_jumpers_t jumpers,
  output logic [7:0] main_status,
  output logic [7:0] aux_status
);
  import blj_pkg::*;

  logic [7:0] fitted_high;
  logic [7:0] fitted_low;

  // Active-high bits copy the jumper straight through
  always_comb begin
    fitted_high = 8'h00;
    fitted_high[MAIN_CONSOLE_EN_BIT] =
      jumpers.console_enable_jumper;
    fitted_high[MAIN_FLASH_WE_BIT] =
      jumpers.flash_write_enable_jumper;
  end

  // Active-low bits read zero with the jumper in place
  always_comb begin
    fitted_low = 8'h00;
    fitted_low[MAIN_CONSOLE_SWAP_BIT] =
      !jumpers.console_swap_jumper;
    fitted_low[MAIN_USER_A_BIT] =
      !jumpers.user_jumper_a;
  end

  // Four jumpers share one byte; unused bits read zero
  assign main_status = fitted_high | fitted_low;

  always_comb begin
    aux_status = 8'h00;
    aux_status[AUX_USER_B_BIT] = jumpers.user_jumper_b;
  end

endmodule // blj_status_pack

////////////////////////////////////////////////////////////////////////
// Board settings driven by the straps

module blj_settings_map (
  input wire blj_pkg::blj_jumpers_t jumpers,
  output blj_pkg::blj_settings_t settings_d
);
  import blj_pkg::*;

  // Swap alone routes nowhere: enable is the master switch
  function automatic logic [1:0] route_of(
    input logic enable_fitted,
    input logic swap_fitted
  );
    logic [1:0] route;
    route = CONSOLE_OFF;
    if (enable_fitted) begin
      if (swap_fitted) begin
        route = CONSOLE_SECOND;
      end else begin
        route = CONSOLE_FIRST;
      end
    end
    return route;
  endfunction

  logic boot_serial;
  logic [1:0] console_route;
  logic flash_writable;

  // Recovery boot pulls the image over the first serial port
  assign boot_serial = jumpers.boot_recovery_jumper;

  assign console_route = route_of(
    jumpers.console_enable_jumper,
    jumpers.console_swap_jumper
  );

  // No jumper, no flash writes: protection is the safe default
  assign flash_writable = jumpers.flash_write_enable_jumper;

  always_comb begin
    settings_d = '0;
    settings_d.boot_from_serial = boot_serial;
    settings_d.console_route = console_route;
    settings_d.flash_write_enable = flash_writable;
  end

endmodule // blj_settings_map

////////////////////////////////////////////////////////////////////////
// User LEDs: control register and pin flops

module blj_led_bank (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic led_wr,
  input wire logic [31:0] wr_data,
  output logic [1:0] led_q,
  output logic led_red,
  output logic led_green
);
  import blj_pkg::*;

  logic [1:0] led_d;
  logic [1:0] led_pin_q;

  always_comb begin
    led_d = led_q;
    if (led_wr) begin
      led_d[LED_RED_BIT] = wr_data[LED_RED_BIT];
      led_d[LED_GREEN_BIT] = wr_data[LED_GREEN_BIT];
    end
  end

  // Lit from reset on, so the board shows life before code runs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      led_q <= LED_RESET;
    end else begin
      led_q <= led_d;
    end
  end

  // One extra flop keeps the pins glitch free; costs a cycle
  for (genvar i = 0; i < 2; i++) begin : g_pin
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        led_pin_q[i] <= LED_RESET[i];
      end else begin
        led_pin_q[i] <= led_q[i];
      end
    end
  end

  assign led_red = led_pin_q[LED_RED_BIT];
  assign led_green = led_pin_q[LED_GREEN_BIT];

endmodule // blj_led_bank

// ==== logic/blj_pkg.sv ====
/*
  Package for the board LED and jumper status block: register byte
  addresses, field positions and reset values.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package blj_pkg;

  localparam logic [31:0] ADDR_JUMPER_STATUS_MAIN = 32'h1080_0000;
  localparam logic [31:0] ADDR_JUMPER_STATUS_AUX = 32'h2280_0000;
  localparam logic [31:0] ADDR_LED_CONTROL = 32'h8084_0020;
  // Own choice: board setting readback, not printed elsewhere
  localparam logic [31:0] ADDR_BOARD_SETTINGS = 32'h8084_0024;

  localparam int LED_GREEN_BIT = 0;
  localparam int LED_RED_BIT = 1;
  localparam int MAIN_CONSOLE_EN_BIT = 0;
  localparam int MAIN_FLASH_WE_BIT = 1;
  localparam int MAIN_CONSOLE_SWAP_BIT = 3;
  localparam int MAIN_USER_A_BIT = 4;
  localparam int AUX_USER_B_BIT = 0;

  localparam logic [1:0] LED_RESET = 2'h3;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

  // Console routing encodings
  localparam logic [1:0] CONSOLE_OFF = 2'h0;
  localparam logic [1:0] CONSOLE_FIRST = 2'h1;
  localparam logic [1:0] CONSOLE_SECOND = 2'h2;

  typedef struct packed {
    logic boot_recovery_jumper;
    logic console_enable_jumper;
    logic flash_write_enable_jumper;
    logic console_swap_jumper;
    logic user_jumper_a;
    logic user_jumper_b;
  } blj_jumpers_t;

  typedef struct packed {
    logic boot_from_serial;
    logic [1:0] console_route;
    logic flash_write_enable;
  } blj_settings_t;

endpackage

// ==== sim/blj_asserts.sv ====
/* Checker for blj_top ports.
   Assumes it is bound to blj_top. */
`timescale 1ns/1ps
module blj_asserts (
  input wire logic clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic led_red, led_green,
  input wire logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire blj_pkg::blj_jumpers_t jumpers,
  input wire blj_pkg::blj_settings_t settings
);
  import blj_pkg::*;
  wire t = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire rd = t & !wb_we_i;
  // Fitted swap and user A read zero
  wire [7:0] main_e = {3'h0, !jumpers[1], !jumpers[2], 1'h0, jumpers[3],
    jumpers[4]};
  wire [1:0] rt_e = !jumpers[4] ? CONSOLE_OFF : jumpers[2] ?
    CONSOLE_SECOND : CONSOLE_FIRST;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  ack_pulse_a: assert property (t |=> s_ack) else $error("ack");
  led_write_a: assert property (t && wb_we_i && wb_sel_i[0] &&
    wb_adr_i == ADDR_LED_CONTROL |-> ##3
    {led_red, led_green} == $past(wb_dat_i[1:0], 3)) else $error("led");
  main_read_a: assert property (rd &&
    wb_adr_i == ADDR_JUMPER_STATUS_MAIN |=> wb_dat_o == $past(main_e))
    else $error("main");
  aux_read_a: assert property (rd &&
    wb_adr_i == ADDR_JUMPER_STATUS_AUX |=> wb_dat_o == $past(jumpers[0]))
    else $error("aux");
  boot_select_a: assert property ($past(arst_n) |->
    settings[3] == $past(jumpers[5])) else $error("boot");
  console_route_a: assert property ($past(arst_n) |->
    settings[2:1] == $past(rt_e)) else $error("route");
  flash_protect_a: assert property ($past(arst_n) |->
    settings[0] == $past(jumpers[3])) else $error("flash");
  led_power_a: assert property ($rose(arst_n) |->
    led_red && led_green) else $error("power");
endmodule // blj_asserts
bind blj_top blj_asserts chk (.*);

// ==== sim/blj_top_tb.sv ====
/* Bench for blj_top: jumper table, LED writes, resets.
   Assumes classic Wishbone at 250 MHz. */
`timescale 1ns/1ps
module blj_top_tb;
  import blj_pkg::*;
  logic clk = 0, arst_n = 0, cyc = 0, we = 0, ack, rl, gl;
  logic [31:0] adr = '0, dat = '0, dout, q;
  logic [3:0] sel = '0;
  blj_jumpers_t jmp = '0;
  blj_settings_t st;
  int err_total = 0, checks = 0;
  logic [18:0] rows [5] = '{{6'h00, 8'h18, 1'h0, 4'h0},
    {6'h3F, 8'h03, 1'h1, 4'hD}, {6'h14, 8'h11, 1'h0, 4'h4},
    {6'h2A, 8'h0A, 1'h0, 4'h9}, {6'h05, 8'h10, 1'h1, 4'h0}};
  always #2 clk = ~clk;
  blj_top dut (.clk, .arst_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dout),
    .wb_ack_o(ack), .jumpers(jmp), .led_red(rl), .led_green(gl),
    .settings(st));
  task automatic chk(string n, logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("err %0d chk %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait: a lost ack ends the run
  task automatic wb(logic w, logic [31:0] a, d, logic [3:0] s);
    int n = 0;
    {cyc, we, adr, dat, sel} <= {1'h1, w, a, d, s};
    do @(posedge clk); while (ack !== 1'h1 && ++n < 50);
    if (n >= 50) begin
      err_total++;
      finish_test;
    end
    q = dout;
    cyc <= 1'h0;
    @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    chk("pwr", 2'h3, {rl, gl});
    foreach (rows[i]) begin
      jmp <= rows[i][18:13];
      wb(0, ADDR_JUMPER_STATUS_MAIN, 0, 4'hF);
      chk("main", rows[i][12:5], q);
      wb(0, ADDR_JUMPER_STATUS_AUX, 0, 4'hF);
      chk("aux", rows[i][4], q);
      chk("set", rows[i][3:0], st);
      wb(0, ADDR_BOARD_SETTINGS, 0, 4'hF);
      chk("setrd", rows[i][3:0], q);
    end
    for (int v = 3; v >= 0; v--) begin
      wb(1, ADDR_LED_CONTROL, v, 4'h1);
      @(posedge clk);
      chk("pins", v, {rl, gl});
      wb(0, ADDR_LED_CONTROL, 0, 4'hF);
      chk("ledrd", v, q);
    end
    wb(1, ADDR_LED_CONTROL, 3, 4'h2);
    wb(1, ADDR_JUMPER_STATUS_MAIN, '1, 4'hF);
    wb(0, ADDR_LED_CONTROL, 0, 4'hF);
    chk("sel", 2'h0, q);
    wb(0, ADDR_JUMPER_STATUS_MAIN, 0, 4'hF);
    chk("ro", 8'h10, q);
    wb(0, 32'h0000_0100, 0, 4'hF);
    chk("unmap", RDATA_UNMAPPED, q);
    arst_n <= 1'h0;
    @(posedge clk);
    chk("rst", 2'h3, {rl, gl});
    chk("rstset", 4'h0, st);
    chk("rstack", 1'h0, ack);
    finish_test;
  end
endmodule // blj_top_tb
